// [hdl/tcp_pkg.sv]
// Purpose: Shared constants and types of the compare/PWM timer block
// Assumes: 32-bit Avalon-MM register window, one word per register
// Notes: Mode codes are the three-bit output action encodings
`default_nettype none
package tcp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_IEN = 8'h08;
    localparam logic [7:0] OFS_EVT = 8'h0c;
    localparam logic [7:0] OFS_CNT = 8'h10;
    localparam logic [7:0] OFS_RLD = 8'h14;
    localparam logic [7:0] OFS_CHM = 8'h18;
    localparam logic [7:0] OFS_CHO = 8'h1c;
    localparam logic [7:0] OFS_CMP0 = 8'h20;
    // Control register fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIR = 1;
    localparam int CTRL_ALN = 2;
    localparam int CTRL_OPM = 4;
    localparam int CTRL_ARP = 5;
    localparam int CTRL_DSRC = 6;
    // Status and enable fields
    localparam int STAT_UPD = 0;
    localparam int STAT_CMP = 1;
    localparam int IEN_DMA = 8;
    localparam int EVT_UPD = 0;
    localparam int CHM_STRIDE = 8;
    localparam int CHO_STRIDE = 2;
    // Reset values
    localparam logic [31:0] RST_RLD = 32'h0000ffff;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    // Output action codes
    localparam logic [2:0] MD_FROZEN = 3'h0;
    localparam logic [2:0] MD_SET = 3'h1;
    localparam logic [2:0] MD_CLR = 3'h2;
    localparam logic [2:0] MD_TOG = 3'h3;
    localparam logic [2:0] MD_FLO = 3'h4;
    localparam logic [2:0] MD_FHI = 3'h5;
    localparam logic [2:0] MD_PWM1 = 3'h6;
    localparam logic [2:0] MD_PWM2 = 3'h7;
    // Alignment codes
    localparam logic [1:0] ALN_EDGE = 2'h0;
    localparam logic [1:0] ALN_DOWN = 2'h1;
    localparam logic [1:0] ALN_UP = 2'h2;
    localparam logic [1:0] ALN_BOTH = 2'h3;

    typedef struct packed {
        logic reference_clear_enable;
        logic fast_output_enable;
        logic compare_preload_enable;
        logic [2:0] output_action_select;
    } tcp_chcfg_s;
endpackage
`default_nettype wire

// [hdl/tcp_channel.sv]
// Purpose: One compare channel: shadow compare, match, reference, pin
// Assumes: Counter, direction and update event come from the timer core
// Notes: Pin level is registered, so it trails the reference by a cycle
`default_nettype none
module tcp_channel #(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Configuration
    input wire tcp_pkg::tcp_chcfg_s cfg_i,
    input wire logic pol_i,
    input wire logic en_i,
    input wire logic [CW-1:0] cmp_pre_i,
    input wire logic cmp_wr_i,
    input wire logic [CW-1:0] wdata_i,
    // Timer core
    input wire logic uev_i,
    input wire logic tick_i,
    input wire logic trig_i,
    input wire logic [CW-1:0] cnt_i,
    input wire logic dir_i,
    input wire logic [1:0] aln_i,
    input wire logic [CW-1:0] rld_i,
    input wire logic etr_i,
    // Results
    output logic match_o,
    output logic ref_o,
    output logic pin_o,
    output logic oe_o
);
    import tcp_pkg::*;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [CW-1:0] shadow_r;
    logic skip_r, oc_r, fast_r, clr_r, pin_r, oe_r;
    logic hit, forced, pwm, pwm1, clr_now, base;
    logic [2:0] md;

    assign md = cfg_i.output_action_select;
    assign forced = (md == MD_FLO) || (md == MD_FHI);
    assign pwm = (md == MD_PWM1) || (md == MD_PWM2);

    // Working copy of the compare value
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            shadow_r <= '0;
            skip_r <= 1'b0;
        end else if (uev_i && cfg_i.compare_preload_enable) begin
            shadow_r <= cmp_pre_i;
            // A drop from full scale to zero must not fire at zero
            skip_r <= (shadow_r >= rld_i) && (cmp_pre_i == '0);
        end else if (cmp_wr_i && !cfg_i.compare_preload_enable) begin
            shadow_r <= wdata_i;
            skip_r <= 1'b0;
        end
    end

    // Compared on every counter step, one count resolution
    assign hit = tick_i && (cnt_i == shadow_r) && !skip_r;

    always_comb begin
        case (aln_i)
            ALN_DOWN: match_o = hit && dir_i;
            ALN_UP: match_o = hit && !dir_i;
            default: match_o = hit;
        endcase
    end

    // Output compare level
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            oc_r <= 1'b0;
        end else if (hit) begin
            case (md)
                MD_SET: oc_r <= 1'b1;
                MD_CLR: oc_r <= 1'b0;
                MD_TOG: oc_r <= !oc_r;
                default: oc_r <= oc_r;
            endcase
        end
    end

    // Fast enable holds the match level until the period ends
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fast_r <= 1'b0;
        end else begin
            fast_r <= (trig_i && cfg_i.fast_output_enable && pwm)
                || (fast_r && !uev_i);
        end
    end

    // Clearing latch, set wins over the update event
    assign clr_now = cfg_i.reference_clear_enable && etr_i && !forced;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            clr_r <= 1'b0;
        end else begin
            clr_r <= clr_now || (clr_r && !uev_i);
        end
    end

    // Down counting treats equality as high except at zero
    assign pwm1 = dir_i ? ((cnt_i <= shadow_r) && (shadow_r != '0))
                        : (cnt_i < shadow_r);

    always_comb begin
        case (md)
            MD_FLO: base = 1'b0;
            MD_FHI: base = 1'b1;
            MD_PWM1: base = fast_r ? 1'b0 : pwm1;
            MD_PWM2: base = fast_r ? 1'b1 : !pwm1;
            default: base = oc_r;
        endcase
    end

    // Active-high reference, polarity only at the pin
    assign ref_o = base && (forced || !(clr_r || clr_now));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            pin_r <= ref_o ^ pol_i;
            oe_r <= en_i;
        end
    end
    assign pin_o = pin_r;
    assign oe_o = oe_r;

    sequence s_toggle_hit;
        hit && (md == MD_TOG);
    endsequence

    a_oc_toggle: assert property (s_toggle_hit |=> oc_r != $past(oc_r))
        else $error("toggle action did not flip the level");
    a_pwm1_up: assert property ((md == MD_PWM1) && !fast_r && !clr_r
        && !clr_now && !dir_i |-> ref_o == (cnt_i < shadow_r))
        else $error("pwm mode 1 level wrong while counting up");
    a_clear_hold: assert property (clr_r && !uev_i && !forced
        ##1 !forced |-> !ref_o)
        else $error("cleared reference rose before update");
    a_preload_wait: assert property (cfg_i.compare_preload_enable
        && cmp_wr_i && !uev_i |=> $stable(shadow_r))
        else $error("preloaded compare loaded early");
    a_pin_polar: assert property (1'b1 |=> pin_o == $past(ref_o ^ pol_i)
        && oe_o == $past(en_i))
        else $error("pin level or enable wrong");
endmodule
`default_nettype wire

// [hdl/tcp_timer.sv]
// Summary of operation
// - Match applies hold, set, clear or toggle
// - Match sets channel flag, interrupt if enabled
// - Match requests DMA when enabled and selected
// - Compare preload defers load to update event
// - Output timing resolves to one counter step
// - Codes 110 and 111 select complementary PWM
// - PWM compares counter against compare every count
// - Preloaded working copies load only on update events
// - Center alignment codes 1 and 2 gate flag by direction
// - Hardware owns direction in center-aligned counting
// - Center counter write at 0 or reload sets direction
// - Up PWM1 high while counter below compare
// - Down PWM1 low while counter above compare
// - Preloaded full-scale to zero compare skips zero event
// - Single pulse stops counter after overflow update event
// - Fast enable forces match level on trigger
// - External trigger clears reference until update
// - Debug halt may freeze the counter
// - Pin shows reference with polarity when enabled
// - Active-high reference, polarity applied last
//
// Purpose: Timer counter with compare/PWM output channels, Avalon slave
// Assumes: Trigger and debug inputs are synchronous to sys_clk_i
// Notes: Every access takes two cycles; the second completes it
`default_nettype none
module tcp_timer #(
    parameter int NCH = 4,
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Trigger and debug
    input wire logic trig_i,
    input wire logic filtered_external_trigger_i,
    input wire logic dbg_halt_i,
    input wire logic debug_halt_freeze_i,
    // Channel pins and requests
    output logic [NCH-1:0] ch_out_o,
    output logic [NCH-1:0] ch_oe_o,
    output logic irq_o,
    output logic [NCH-1:0] dma_req_o
);
    import tcp_pkg::*;

    // Register layout packs at most four channels into CHM, CHO and IEN
    if (NCH < 1 || NCH > 4 || CW < 2 || CW > 32) begin : gen_bad_param
        $error("tcp_timer: NCH must be 1..4 and CW 2..32");
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic ack_r;
    logic [31:0] rdata_r;
    logic acc, wr_acc;
    logic cnt_en_r, dir_r, opm_r, arp_r, dsrc_r;
    logic [1:0] aln_r;
    logic [CW-1:0] cnt_r, rld_pre_r, rld_r;
    logic [CW-1:0] cmp_pre_r [NCH];
    tcp_chcfg_s chm_r [NCH];
    logic [NCH-1:0] cho_en_r, cho_pol_r, den_r, cmp_flag_r, dma_r;
    logic [NCH:0] ien_r;
    logic upd_flag_r, irq_r;
    logic tick, center, ovf, sw_ug, hw_uev, update_event, cnt_wr;
    logic [NCH-1:0] ev, cmp_wr, ref_w;
    logic [31:0] rdata_nxt;
    logic [CW-1:0] wd;

    // Bus: one wait cycle, then the request completes
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
    assign acc = (avs_read_i || avs_write_i) && ack_r;
    assign wr_acc = avs_write_i && ack_r;
    assign wd = avs_writedata_i[CW-1:0];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_i || avs_write_i) && !ack_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= RST_ZERO;
        end else if (avs_read_i && !ack_r) begin
            rdata_r <= rdata_nxt;
        end
    end
    assign avs_readdata_o = rdata_r;

    // Counter control
    assign center = (aln_r != ALN_EDGE);
    assign tick = cnt_en_r
        && !(dbg_halt_i && debug_halt_freeze_i);
    assign ovf = dir_r ? (cnt_r == '0)
        : (center ? (cnt_r >= rld_r) : (cnt_r == rld_r));
    assign sw_ug = wr_acc && (avs_address_i == OFS_EVT)
        && avs_writedata_i[EVT_UPD];
    assign hw_uev = tick && ovf;
    assign update_event = sw_ug || hw_uev;
    assign cnt_wr = wr_acc && (avs_address_i == OFS_CNT);

    // Configuration bits of the control register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aln_r <= ALN_EDGE;
            opm_r <= 1'b0;
            arp_r <= 1'b0;
            dsrc_r <= 1'b0;
        end else if (wr_acc && avs_address_i == OFS_CTRL) begin
            aln_r <= avs_writedata_i[CTRL_ALN +: 2];
            opm_r <= avs_writedata_i[CTRL_OPM];
            arp_r <= avs_writedata_i[CTRL_ARP];
            dsrc_r <= avs_writedata_i[CTRL_DSRC];
        end
    end

    // Run bit: trigger starts, single pulse stops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_en_r <= 1'b0;
        end else if (wr_acc && avs_address_i == OFS_CTRL) begin
            cnt_en_r <= avs_writedata_i[CTRL_EN];
        end else if (opm_r && hw_uev) begin
            cnt_en_r <= 1'b0;
        end else if (trig_i) begin
            cnt_en_r <= 1'b1;
        end
    end

    // Counter and direction
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
            dir_r <= 1'b0;
        end else if (sw_ug) begin
            cnt_r <= (dir_r && !center) ? rld_pre_r : '0;
            if (center)
                dir_r <= 1'b0;
        end else if (cnt_wr) begin
            cnt_r <= wd;
            if (center && wd == '0)
                dir_r <= 1'b0;
            else if (center && wd == rld_r)
                dir_r <= 1'b1;
        end else if (wr_acc && avs_address_i == OFS_CTRL && !center
                     && avs_writedata_i[CTRL_ALN +: 2] == ALN_EDGE) begin
            // Software direction only counts in edge alignment
            dir_r <= avs_writedata_i[CTRL_DIR];
        end else if (tick) begin
            if (!center) begin
                if (ovf)
                    cnt_r <= dir_r ? rld_r : '0;
                else
                    cnt_r <= dir_r ? cnt_r - 1'b1 : cnt_r + 1'b1;
            end else if (ovf) begin
                cnt_r <= dir_r ? cnt_r + 1'b1 : cnt_r - 1'b1;
                dir_r <= !dir_r;
            end else begin
                cnt_r <= dir_r ? cnt_r - 1'b1 : cnt_r + 1'b1;
            end
        end
    end

    // Reload limit with optional preload
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rld_pre_r <= RST_RLD[CW-1:0];
            rld_r <= RST_RLD[CW-1:0];
        end else begin
            if (wr_acc && avs_address_i == OFS_RLD) begin
                rld_pre_r <= wd;
                if (!arp_r)
                    rld_r <= wd;
            end
            if (update_event && arp_r)
                rld_r <= rld_pre_r;
        end
    end

    // Channel configuration and compare preload registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NCH; i++) begin
                chm_r[i] <= '0;
                cmp_pre_r[i] <= '0;
            end
            cho_en_r <= '0;
            cho_pol_r <= '0;
        end else if (wr_acc) begin
            for (int i = 0; i < NCH; i++) begin
                if (avs_address_i == OFS_CHM)
                    chm_r[i] <= avs_writedata_i[i*CHM_STRIDE +: 6];
                if (avs_address_i == OFS_CHO) begin
                    cho_en_r[i] <= avs_writedata_i[i*CHO_STRIDE];
                    cho_pol_r[i] <= avs_writedata_i[i*CHO_STRIDE+1];
                end
                if (cmp_wr[i])
                    cmp_pre_r[i] <= wd;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++)
            cmp_wr[i] = wr_acc
                && (avs_address_i == OFS_CMP0 + 8'(4 * i));
    end

    // Interrupt and DMA enables
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ien_r <= '0;
            den_r <= '0;
        end else if (wr_acc && avs_address_i == OFS_IEN) begin
            ien_r <= avs_writedata_i[NCH:0];
            den_r <= avs_writedata_i[IEN_DMA +: NCH];
        end
    end

    // Status flags: writing 0 clears, a new event wins
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            upd_flag_r <= 1'b0;
            cmp_flag_r <= '0;
        end else if (wr_acc && avs_address_i == OFS_STAT) begin
            upd_flag_r <= (upd_flag_r && avs_writedata_i[STAT_UPD]) || update_event;
            cmp_flag_r <= (cmp_flag_r
                & avs_writedata_i[STAT_CMP +: NCH]) | ev;
        end else begin
            upd_flag_r <= upd_flag_r || update_event;
            cmp_flag_r <= cmp_flag_r | ev;
        end
    end

    // Requests out
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            irq_r <= 1'b0;
            dma_r <= '0;
        end else begin
            irq_r <= |({cmp_flag_r, upd_flag_r} & ien_r);
            dma_r <= den_r & (dsrc_r ? ev : {NCH{update_event}});
        end
    end
    assign irq_o = irq_r;
    assign dma_req_o = dma_r;

    // Read back
    always_comb begin
        rdata_nxt = RST_ZERO;
        case (avs_address_i)
            OFS_CTRL: begin
                rdata_nxt[CTRL_EN] = cnt_en_r;
                rdata_nxt[CTRL_DIR] = dir_r;
                rdata_nxt[CTRL_ALN +: 2] = aln_r;
                rdata_nxt[CTRL_OPM] = opm_r;
                rdata_nxt[CTRL_ARP] = arp_r;
                rdata_nxt[CTRL_DSRC] = dsrc_r;
            end
            OFS_STAT: begin
                rdata_nxt[STAT_UPD] = upd_flag_r;
                rdata_nxt[STAT_CMP +: NCH] = cmp_flag_r;
            end
            OFS_IEN: begin
                rdata_nxt[NCH:0] = ien_r;
                rdata_nxt[IEN_DMA +: NCH] = den_r;
            end
            OFS_CNT: rdata_nxt[CW-1:0] = cnt_r;
            OFS_RLD: rdata_nxt[CW-1:0] = rld_pre_r;
            OFS_CHM: begin
                for (int i = 0; i < NCH; i++)
                    rdata_nxt[i*CHM_STRIDE +: 6] = chm_r[i];
            end
            OFS_CHO: begin
                for (int i = 0; i < NCH; i++)
                    rdata_nxt[i*CHO_STRIDE +: 2] = {cho_pol_r[i],
                        cho_en_r[i]};
            end
            default: begin
                for (int i = 0; i < NCH; i++)
                    if (avs_address_i == OFS_CMP0 + 8'(4 * i))
                        rdata_nxt[CW-1:0] = cmp_pre_r[i];
            end
        endcase
    end

    // Output channels
    for (genvar g = 0; g < NCH; g++) begin : gen_ch
        tcp_channel #(.CW(CW)) u_ch (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .cfg_i(chm_r[g]),
            .pol_i(cho_pol_r[g]),
            .en_i(cho_en_r[g]),
            .cmp_pre_i(cmp_pre_r[g]),
            .cmp_wr_i(cmp_wr[g]),
            .wdata_i(wd),
            .uev_i(update_event),
            .tick_i(tick),
            .trig_i(trig_i),
            .cnt_i(cnt_r),
            .dir_i(dir_r),
            .aln_i(aln_r),
            .rld_i(rld_r),
            .etr_i(filtered_external_trigger_i),
            .match_o(ev[g]),
            .ref_o(ref_w[g]),
            .pin_o(ch_out_o[g]),
            .oe_o(ch_oe_o[g])
        );
    end

    sequence s_quiet;
        !wr_acc;
    endsequence

    sequence s_edge_top;
        tick && !center && !dir_r && cnt_r == rld_r;
    endsequence

    a_edge_restart: assert property (s_edge_top and s_quiet
        |=> cnt_r == '0 && upd_flag_r)
        else $error("edge counter did not restart at reload");
    a_single_stop: assert property (opm_r && hw_uev and s_quiet
        |=> !cnt_en_r ##1 !cnt_en_r || $past(trig_i) || $past(wr_acc))
        else $error("single pulse counter kept running");
    a_debug_hold: assert property (dbg_halt_i && debug_halt_freeze_i
        and s_quiet |=> $stable(cnt_r))
        else $error("counter moved during frozen debug halt");
    a_ctr_write: assert property (cnt_wr && center && wd == '0
        |=> !dir_r)
        else $error("center counter write at zero kept direction");
    a_center_flip: assert property (tick && center && !dir_r
        && cnt_r >= rld_r and s_quiet |=> dir_r)
        else $error("center counter did not turn at reload");
    a_flag_event: assert property (ev[0] |=> cmp_flag_r[0] ##1
        irq_r || !$past(ien_r[1]))
        else $error("compare flag or interrupt missing");
    a_dma_event: assert property (ev[0] && den_r[0] && dsrc_r
        |=> dma_req_o[0])
        else $error("compare DMA request missing");
    a_bus_answer: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered in one wait cycle");
endmodule
`default_nettype wire

// [verification/tcp_far_end.sv]
// Purpose: Far side of the timer: pin line and current comparator
// Assumes: The pin line has a pull-down while the pin is not driven
// Notes: Comparator level is unprescaled and never used as a clock
`default_nettype none
module tcp_far_end (
    // Clock
    input wire logic sys_clk_i,
    // Pin and comparator
    input wire logic pin_i,
    input wire logic oe_i,
    input wire logic trip_i,
    output logic etr_o,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pin falls to the pull-down level
    assign line_o = oe_i ? pin_i : 1'b0;
    // Plain level, no prescale and no clock mode
    assign etr_o = trip_i;
endmodule
`default_nettype wire

// [verification/tcp_tb.sv]
// Purpose: Self-checking bench of the compare/PWM timer
// Assumes: Reload 7 gives 8-cycle edge periods, 14-cycle center periods
// Notes: Windows span whole periods, so counts do not depend on phase
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tcp_pkg::*;
    logic sys_clk_i = 0, rst_n_i = 0, rd = 0, wr = 0, trip = 0;
    logic halt = 0, frz = 0, trg = 0, wreq, irq, etr, line;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q, v, c, seed = 32'h925d;
    logic [3:0] pin, oe, dma;
    int miscompares = 0, checked = 0, hi, np;
    int md[10] = '{0, 1, 2, 3, 6, 7, 6, 6, 6, 7};
    int pl[10] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0};
    int cm[10] = '{3, 3, 3, 3, 3, 3, 3, 0, 9, 9};
    int eh[10] = '{0, 64, 0, 32, 24, 40, 40, 0, 64, 0};
    int ed[10] = '{8, 8, 8, 8, 8, 8, 8, -1, 0, 0};

    tcp_timer #(.NCH(4), .CW(16)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .trig_i(trg),
        .filtered_external_trigger_i(etr), .dbg_halt_i(halt),
        .debug_halt_freeze_i(frz), .ch_out_o(pin), .ch_oe_o(oe),
        .irq_o(irq), .dma_req_o(dma));
    tcp_far_end u_far (.sys_clk_i(sys_clk_i), .pin_i(pin[0]),
        .oe_i(oe[0]), .trip_i(trip), .etr_o(etr), .line_o(line));

    initial forever #25 sys_clk_i = ~sys_clk_i;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            $display("ERROR %0t bus request not answered", $time);
        end
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic measure(input int nc);
        hi = 0;
        np = 0;
        repeat (nc) begin
            @(posedge sys_clk_i);
            hi += (line === 1'b1);
            np += (dma[0] === 1'b1);
        end
    endtask

    // Software forces an update before starting the counter
    task automatic run(input int m, input int p, input logic [31:0] cv,
                       input logic [31:0] ctl);
        bus(1, OFS_CTRL, 32'h0);
        bus(1, OFS_RLD, 32'h7);
        // Mode first, so the compare write sees this run's preload choice
        bus(1, OFS_CHM, 32'(m));
        bus(1, OFS_CMP0, cv);
        bus(1, OFS_CHO, 32'(p * 2 + 1));
        bus(1, OFS_IEN, 32'h102);
        bus(1, OFS_EVT, 32'h1);
        bus(1, OFS_CTRL, ctl);
        repeat (16) @(posedge sys_clk_i);
    endtask

    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        $display("ERROR %0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        bus(0, OFS_RLD, 32'h0);
        chk(q, RST_RLD);
        bus(0, OFS_CTRL, 32'h0);
        chk(q, RST_ZERO);
        bus(0, 8'hfc, 32'h0);
        chk(q, RST_ZERO);
        for (int i = 0; i < 10; i++) begin
            run(md[i], pl[i], 32'(cm[i]), 32'h41);
            measure(64);
            chk(hi, eh[i]);
            if (ed[i] >= 0) chk(np, ed[i]);
        end
        for (int i = 0; i < 3; i++) begin
            c = rnd() % 7 + 1;
            run(6, 0, c, 32'h41);
            measure(64);
            chk(hi, c * 8);
        end
        // Preloaded compare: new value lands at the next update
        run(32'he, 0, 32'h3, 32'h41);
        bus(1, OFS_CMP0, 32'h5);
        repeat (16) @(posedge sys_clk_i);
        measure(64);
        chk(hi, 40);
        bus(0, OFS_STAT, 32'h0);
        chk(q[STAT_CMP], 1'b1);
        chk(irq, 1'b1);
        bus(1, OFS_IEN, 32'h100);
        bus(1, OFS_STAT, 32'h0);
        repeat (4) @(posedge sys_clk_i);
        chk(irq, 1'b0);
        run(32'h26, 0, 32'h9, 32'h41);
        trip <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        measure(64);
        chk(hi, 0);
        trip <= 1'b0;
        repeat (16) @(posedge sys_clk_i);
        measure(64);
        chk(hi, 64);
        for (int a = 1; a < 4; a++) begin
            run(6, 0, 32'h3, 32'(32'h41 | (a << 2)));
            measure(56);
            chk(np, a == 3 ? 8 : 4);
        end
        // Counter writes in center mode set the direction
        bus(1, OFS_CNT, 32'h0);
        bus(0, OFS_CTRL, 32'h0);
        chk(q[CTRL_DIR], 1'b0);
        bus(1, OFS_CNT, 32'h7);
        bus(0, OFS_CTRL, 32'h0);
        chk(q[CTRL_DIR], 1'b1);
        run(7, 0, 32'h3, 32'h51);
        bus(0, OFS_CTRL, 32'h0);
        chk(q[CTRL_EN], 1'b0);
        measure(16);
        chk(np, 0);
        chk(hi, 0);
        // Trigger restarts the stopped counter; fast enable rises at once
        bus(1, OFS_CHM, 32'h17);
        trg <= 1'b1;
        @(posedge sys_clk_i);
        trg <= 1'b0;
        measure(16);
        chk(hi, 8);
        run(6, 0, 32'h3, 32'h41);
        halt <= 1'b1;
        frz <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        bus(0, OFS_CNT, 32'h0);
        v = q;
        bus(0, OFS_CNT, 32'h0);
        chk(q, v);
        frz <= 1'b0;
        bus(0, OFS_CNT, 32'h0);
        v = q;
        bus(0, OFS_CNT, 32'h0);
        chk(q !== v, 1'b1);
        results();
    end
endmodule
`default_nettype wire
